// ### sec_pkg.sv
package sec_pkg;

  // Clock and serial timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCLK_HALF_NS = 200;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Frame geometry
  localparam logic [4:0] FRAME_BITS_PLAIN = 5'd16;
  localparam logic [4:0] FRAME_BITS_CRC = 5'd24;
  localparam logic [4:0] ADDR_DONE_BIT = 5'd7;
  localparam logic [4:0] CMD_BITS = 5'd16;
  localparam logic [15:0] CLEAR_CMD = 16'h6ca9;

  // Device register map
  localparam logic [6:0] ADDR_SWITCH = 7'h01;
  localparam logic [6:0] ADDR_FAULT_SETUP = 7'h02;
  localparam logic [6:0] ADDR_FAULT_STATUS = 7'h03;
  localparam logic [6:0] ADDR_BURST = 7'h05;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h0b;

  // Reset values and fields
  localparam logic [7:0] SWITCH_RESET = 8'h00;
  localparam logic [2:0] SETUP_RESET = 3'h6;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic BURST_RESET = 1'b0;
  localparam int BIT_ADDR_CHK = 2;
  localparam int BIT_CLK_CHK = 1;
  localparam int BIT_CRC_CHK = 0;
  localparam logic [7:0] SOFT_KEY1 = 8'ha3;
  localparam logic [7:0] SOFT_KEY2 = 8'h05;

  // CRC-8, polynomial x^8+x^2+x+1, seed zero
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_SEED = 8'h00;

  // Controller register map
  localparam logic [1:0] CREG_FRAME = 2'h0;
  localparam logic [1:0] CREG_CTRL = 2'h1;
  localparam logic [1:0] CREG_STATUS = 2'h2;
  localparam logic [1:0] CREG_RDATA = 2'h3;

  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic b);
    logic fb;
    fb = crc[7] ^ b;
    return {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] crc8_word(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = 15; i >= 0; i--) begin
      c = crc8_step(c, w[i]);
    end
    return c;
  endfunction

endpackage

// ### sec_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sec_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  modport dev (input cs_n, input sclk, input sdi, output sdo);
  modport ctl (output cs_n, output sclk, output sdi, input sdo);
endinterface
`default_nettype wire

// ### sec_device.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Setup register at 0x02, resets to 0x06
// - Setup bits 7:3 read zero, writes ignored
// - Setup bit 2 enables bad-address detection
// - Setup bit 1 enables clock-count check
// - No CRC, no burst: exactly 16 clocks
// - CRC, no burst: exactly 24 clocks
// - Burst, no CRC: multiple of 16 clocks
// - Burst with CRC: multiple of 24 clocks
// - Setup bit 0 enables CRC checking
// - CRC enabled makes frames 24 bits
// - Status register at 0x03, resets to 0x00
// - Command 0x6ca9 clears all status flags
// - Clear command never flags bad address
// - Clear needs matching CRC when CRC enabled
// - Status bit 2: bad read/write address
// - Status bit 1: wrong clock count
// - Status bit 0: CRC mismatch on write
// - Burst runs several commands per select
module sec_device
  import sec_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Serial link
  sec_link_if.dev link,
  // Register contents
  output logic [7:0] o_switch_state,
  output logic [7:0] o_fault_setup,
  output logic [7:0] o_fault_status,
  output logic o_burst_mode
);

  logic sclk_q_reg;
  logic cs_n_q_reg;
  logic [23:0] shift_in_reg;
  logic [4:0] bit_cnt_reg;
  logic [1:0] frames_reg;
  logic [7:0] crc_reg;
  logic [7:0] sdo_sh_reg;
  logic sdo_reg;
  logic pend_valid_reg;
  logic [6:0] pend_addr_reg;
  logic [7:0] pend_data_reg;
  logic [7:0] switch_reg;
  logic [2:0] setup_reg;
  logic [2:0] status_reg;
  logic burst_reg;
  logic soft_armed_reg;

  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic selected;
  logic [4:0] frame_bits;
  logic [23:0] word;
  logic frame_end;
  logic [15:0] cmd;
  logic crc_ok;
  logic [6:0] addr;
  logic is_read;
  logic take_frame;
  logic count_ok;
  logic clear_req;
  logic [2:0] flag_set;
  logic pend_load;
  logic commit;
  logic [6:0] commit_addr;
  logic [7:0] commit_data;
  logic soft_reset;
  logic [6:0] early_addr;

  function automatic logic readable(input logic [6:0] a);
    return a == ADDR_SWITCH || a == ADDR_FAULT_SETUP || a == ADDR_FAULT_STATUS || a == ADDR_BURST;
  endfunction

  function automatic logic writable(input logic [6:0] a);
    return a == ADDR_SWITCH || a == ADDR_FAULT_SETUP || a == ADDR_BURST || a == ADDR_SOFT_RESET;
  endfunction

  assign selected = !link.cs_n;
  assign sclk_rise = selected && link.sclk && !sclk_q_reg;
  assign sclk_fall = selected && !link.sclk && sclk_q_reg;
  assign cs_rise = link.cs_n && !cs_n_q_reg;
  assign frame_bits = setup_reg[BIT_CRC_CHK] ? FRAME_BITS_CRC : FRAME_BITS_PLAIN;
  assign word = {shift_in_reg[22:0], link.sdi};
  assign frame_end = sclk_rise && (bit_cnt_reg == frame_bits - 5'd1);
  assign cmd = setup_reg[BIT_CRC_CHK] ? word[23:8] : word[15:0];
  assign crc_ok = !setup_reg[BIT_CRC_CHK] || (crc_reg == word[7:0]);
  assign addr = cmd[14:8];
  assign is_read = cmd[15];
  assign take_frame = frame_end && (burst_reg || frames_reg == 2'd0);
  assign early_addr = word[6:0];

  // Exact single frame, or whole frames in burst
  assign count_ok = (bit_cnt_reg == 5'd0) && (frames_reg != 2'd0)
                    && (burst_reg || frames_reg == 2'd1);

  always_comb begin
    clear_req = 1'b0;
    flag_set = 3'b000;
    pend_load = 1'b0;
    commit = 1'b0;
    commit_addr = pend_addr_reg;
    commit_data = pend_data_reg;
    if (take_frame) begin
      if (cmd == CLEAR_CMD) begin
        if (crc_ok) begin
          clear_req = 1'b1;
        end else begin
          flag_set[BIT_CRC_CHK] = 1'b1;
        end
      end else if (is_read) begin
        flag_set[BIT_ADDR_CHK] = setup_reg[BIT_ADDR_CHK] && !readable(addr);
      end else if (!crc_ok) begin
        flag_set[BIT_CRC_CHK] = 1'b1;
      end else if (!writable(addr)) begin
        flag_set[BIT_ADDR_CHK] = setup_reg[BIT_ADDR_CHK];
      end else if (burst_reg) begin
        commit = 1'b1;
        commit_addr = addr;
        commit_data = cmd[7:0];
      end else begin
        pend_load = 1'b1;
      end
    end
    if (cs_rise) begin
      flag_set[BIT_CLK_CHK] = setup_reg[BIT_CLK_CHK] && !count_ok;
      commit = pend_valid_reg && count_ok;
    end
  end

  assign soft_reset = commit && commit_addr == ADDR_SOFT_RESET && soft_armed_reg && commit_data == SOFT_KEY2;

  // Pin history
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sclk_q_reg <= 1'b0;
      cs_n_q_reg <= 1'b1;
    end else begin
      sclk_q_reg <= link.sclk;
      cs_n_q_reg <= link.cs_n;
    end
  end

  // Frame counting and CRC accumulation
  always_ff @(posedge i_clk) begin
    if (i_reset || !selected) begin
      shift_in_reg <= 24'h000000;
      bit_cnt_reg <= 5'd0;
      frames_reg <= 2'd0;
      crc_reg <= CRC_SEED;
    end else if (sclk_rise) begin
      shift_in_reg <= word;
      if (bit_cnt_reg < CMD_BITS) begin
        crc_reg <= crc8_step(crc_reg, link.sdi);
      end
      if (frame_end) begin
        bit_cnt_reg <= 5'd0;
        crc_reg <= CRC_SEED;
        if (frames_reg != 2'd3) begin
          frames_reg <= frames_reg + 2'd1;
        end
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 5'd1;
      end
    end
  end

  // Pending write held until deselect
  always_ff @(posedge i_clk) begin
    if (i_reset || cs_rise) begin
      pend_valid_reg <= 1'b0;
      pend_addr_reg <= 7'h00;
      pend_data_reg <= 8'h00;
    end else if (pend_load) begin
      pend_valid_reg <= 1'b1;
      pend_addr_reg <= addr;
      pend_data_reg <= cmd[7:0];
    end
  end

  // Read-back shifter, changes on falling clock
  always_ff @(posedge i_clk) begin
    if (i_reset || !selected) begin
      sdo_sh_reg <= 8'h00;
      sdo_reg <= 1'b0;
    end else if (sclk_rise && bit_cnt_reg == ADDR_DONE_BIT) begin
      if (word[7]) begin
        unique case (early_addr)
          ADDR_SWITCH: sdo_sh_reg <= switch_reg;
          ADDR_FAULT_SETUP: sdo_sh_reg <= {5'b00000, setup_reg};
          ADDR_FAULT_STATUS: sdo_sh_reg <= {5'b00000, status_reg};
          ADDR_BURST: sdo_sh_reg <= {7'h00, burst_reg};
          default: sdo_sh_reg <= 8'h00;
        endcase
      end else begin
        sdo_sh_reg <= 8'h00;
      end
    end else if (sclk_fall) begin
      sdo_reg <= sdo_sh_reg[7];
      sdo_sh_reg <= {sdo_sh_reg[6:0], 1'b0};
    end
  end

  // Writable registers
  always_ff @(posedge i_clk) begin
    if (i_reset || soft_reset) begin
      switch_reg <= SWITCH_RESET;
      setup_reg <= SETUP_RESET;
      burst_reg <= BURST_RESET;
      soft_armed_reg <= 1'b0;
    end else if (commit) begin
      unique case (commit_addr)
        ADDR_SWITCH: switch_reg <= commit_data;
        ADDR_FAULT_SETUP: setup_reg <= commit_data[2:0];
        ADDR_BURST: burst_reg <= commit_data[0];
        ADDR_SOFT_RESET: soft_armed_reg <= commit_data == SOFT_KEY1;
        default: soft_armed_reg <= soft_armed_reg;
      endcase
    end
  end

  // Sticky flags, a new event beats the clear
  always_ff @(posedge i_clk) begin
    if (i_reset || soft_reset) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg <= (clear_req ? STATUS_RESET : status_reg) | flag_set;
    end
  end

  assign link.sdo = sdo_reg;
  assign o_switch_state = switch_reg;
  assign o_fault_setup = {5'b00000, setup_reg};
  assign o_fault_status = {5'b00000, status_reg};
  assign o_burst_mode = burst_reg;

endmodule // sec_device
`default_nettype wire

// ### sec_controller.sv
`timescale 1ns/1ps
`default_nettype none
module sec_controller
  import sec_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [1:0] i_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rd_data,
  // Serial link
  sec_link_if.ctl link
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_SHIFT = 2'b10,
    ST_TRAIL = 2'b11
  } sec_ctl_state_e;

  sec_ctl_state_e state_reg;
  logic [7:0] div_reg;
  logic [23:0] tx_reg;
  logic [15:0] rx_reg;
  logic [4:0] bit_cnt_reg;
  logic [4:0] len_reg;
  logic crc_en_reg;
  logic crc_bad_reg;
  logic done_reg;
  logic [7:0] rdata_reg;
  logic cs_n_reg;
  logic sclk_reg;
  logic [15:0] rd_data_reg;
  logic tick;
  logic start;
  logic finish;

  assign tick = (state_reg != ST_IDLE) && (div_reg == 8'(SCLK_HALF_CYC - 1));
  assign start = i_wr && i_addr == CREG_FRAME && state_reg == ST_IDLE;
  assign finish = tick && state_reg == ST_TRAIL;

  // Half-period divider
  always_ff @(posedge i_clk) begin
    if (i_reset || state_reg == ST_IDLE || tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // Frame sequencing, mode 0 clocking
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
      cs_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
      tx_reg <= 24'h000000;
      rx_reg <= 16'h0000;
      bit_cnt_reg <= 5'd0;
      len_reg <= FRAME_BITS_PLAIN;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_LEAD;
            cs_n_reg <= 1'b0;
            tx_reg <= {i_wr_data, crc8_word(i_wr_data) ^ {7'h00, crc_bad_reg}};
            len_reg <= crc_en_reg ? FRAME_BITS_CRC : FRAME_BITS_PLAIN;
            bit_cnt_reg <= 5'd0;
          end
        end
        ST_LEAD: begin
          if (tick) begin
            state_reg <= ST_SHIFT;
            sclk_reg <= 1'b1;
            rx_reg <= {rx_reg[14:0], link.sdo};
          end
        end
        ST_SHIFT: begin
          if (tick && sclk_reg) begin
            sclk_reg <= 1'b0;
            tx_reg <= {tx_reg[22:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
            if (bit_cnt_reg == len_reg - 5'd1) begin
              state_reg <= ST_TRAIL;
            end
          end else if (tick) begin
            sclk_reg <= 1'b1;
            if (bit_cnt_reg < CMD_BITS) begin
              rx_reg <= {rx_reg[14:0], link.sdo};
            end
          end
        end
        ST_TRAIL: begin
          if (tick) begin
            state_reg <= ST_IDLE;
            cs_n_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  // Control and result registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      crc_en_reg <= 1'b0;
      crc_bad_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      if (i_wr && i_addr == CREG_CTRL) begin
        crc_en_reg <= i_wr_data[0];
        crc_bad_reg <= i_wr_data[1];
      end
      if (finish) begin
        rdata_reg <= rx_reg[7:0];
      end
    end
  end

  // Done flag, set wins over read-clear
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      done_reg <= 1'b0;
    end else if (finish) begin
      done_reg <= 1'b1;
    end else if (i_rd && i_addr == CREG_STATUS) begin
      done_reg <= 1'b0;
    end
  end

  // Read data one cycle after strobe
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rd_data_reg <= 16'h0000;
    end else if (i_rd) begin
      unique case (i_addr)
        CREG_FRAME: rd_data_reg <= tx_reg[23:8];
        CREG_CTRL: rd_data_reg <= {14'h0000, crc_bad_reg, crc_en_reg};
        CREG_STATUS: rd_data_reg <= {14'h0000, done_reg, state_reg != ST_IDLE};
        CREG_RDATA: rd_data_reg <= {8'h00, rdata_reg};
      endcase
    end else begin
      rd_data_reg <= 16'h0000;
    end
  end

  assign link.cs_n = cs_n_reg;
  assign link.sclk = sclk_reg;
  assign link.sdi = tx_reg[23];
  assign o_rd_data = rd_data_reg;

endmodule // sec_controller
`default_nettype wire

// ### sec_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sec_asserts (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Link and device state
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [7:0] o_fault_setup,
  input wire logic [7:0] o_fault_status,
  input wire logic o_burst_mode
);
  logic sclk_q;
  logic crc_q;
  logic [7:0] cnt;
  logic [7:0] flen;
  logic cnt_bad;

  // Expected frame length, frozen for the whole select, and count verdict
  assign flen = crc_q ? 8'h18 : 8'h10;
  assign cnt_bad = o_burst_mode ? (cnt == 8'h00 || cnt % flen != 8'h00) : cnt != flen;

  always_ff @(posedge i_clk) begin
    sclk_q <= sclk;
  end

  // CRC mode as it stood when the select began
  always_ff @(posedge i_clk) begin
    if (cs_n) begin
      crc_q <= o_fault_setup[0];
    end
  end

  // Serial clock rises per select
  always_ff @(posedge i_clk) begin
    if (i_reset || cs_n) begin
      cnt <= 8'h00;
    end else if (sclk && !sclk_q) begin
      cnt <= cnt + 8'h01;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence frame_end;
    $rose(cs_n);
  endsequence

  sequence count_quiet;
    !o_fault_status[1] [*3];
  endsequence

  a_reset_values: assert property ($fell(i_reset) |-> o_fault_setup == 8'h06 && o_fault_status == 8'h00)
    else $error("register reset values wrong");
  a_reserved_zero: assert property (o_fault_setup[7:3] == 5'h00)
    else $error("reserved setup bits not zero");
  a_frame_len: assert property (frame_end |-> cnt == 8'h10 || cnt == 8'h18)
    else $error("frame clock count not 16 or 24");
  a_count_flagged: assert property (frame_end ##0 (o_fault_setup[1] && cnt_bad) |-> ##[1:3] o_fault_status[1])
    else $error("count error not flagged");
  a_count_clean: assert property (frame_end ##0 (!o_fault_status[1] && !cnt_bad) |-> count_quiet)
    else $error("exact count flagged");
  a_count_off: assert property (frame_end ##0 (!o_fault_setup[1] && !o_fault_status[1]) |-> count_quiet)
    else $error("count flag while check off");
  a_flag_sticky: assert property (|($past(o_fault_status) & ~o_fault_status) |-> !cs_n || !$past(cs_n) || !$past(cs_n, 2))
    else $error("flag dropped outside a frame");
  a_setup_at_end: assert property ($changed(o_fault_setup) |-> !$past(cs_n) || !$past(cs_n, 2) || !$past(cs_n, 3))
    else $error("setup changed outside a frame");
endmodule // sec_asserts
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sec_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [1:0] i_addr = 2'h0;
  logic [15:0] i_wr_data = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] o_rd_data;
  logic [7:0] o_switch_state;
  logic [7:0] o_fault_setup;
  logic [7:0] o_fault_status;
  logic o_burst_mode;
  logic [7:0] d;
  logic [15:0] s;
  int n_mismatch = 0;
  int checks = 0;

  sec_link_if link ();
  sec_device sec_device_i (.i_clk(i_clk), .i_reset(i_reset), .link(link.dev), .o_switch_state(o_switch_state),
    .o_fault_setup(o_fault_setup), .o_fault_status(o_fault_status), .o_burst_mode(o_burst_mode));
  sec_controller sec_controller_i (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .link(link.ctl));
  sec_asserts sec_asserts_i (.i_clk(i_clk), .i_reset(i_reset), .cs_n(link.cs_n), .sclk(link.sclk),
    .o_fault_setup(o_fault_setup), .o_fault_status(o_fault_status), .o_burst_mode(o_burst_mode));

  always #(CLK_PERIOD_NS / 2) i_clk = ~i_clk;

  function automatic logic [7:0] setup_val(input logic [7:0] v);
    return {5'h00, v[2:0]};
  endfunction

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rd_data;
  endtask

  // One frame, polled to completion
  task automatic frame(input logic [15:0] w);
    logic [15:0] st;
    st = 16'h0000;
    wr(CREG_FRAME, w);
    for (int i = 0; i < 300 && st[1] !== 1'b1; i++) begin
      rd(CREG_STATUS, st);
    end
    chk("done", {7'h00, st[1]}, 8'h01);
    repeat (4) @(posedge i_clk);
    #1;
  endtask

  task automatic wreg(input logic [6:0] a, input logic [7:0] v);
    frame({1'b0, a, v});
  endtask

  task end_sim;
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #(CLK_PERIOD_NS * 60000);
    n_mismatch++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h8d8e));
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    #1;
    chk("setup", o_fault_setup, 8'h06);
    chk("status", o_fault_status, 8'h00);
    // All checks off, then a bad address and a long frame
    wreg(ADDR_FAULT_SETUP, 8'hf8);
    chk("setup", o_fault_setup, setup_val(8'hf8));
    wr(CREG_CTRL, 16'h0001);
    wreg(7'h7f, 8'h00);
    chk("status", o_fault_status, 8'h00);
    wr(CREG_CTRL, 16'h0000);
    wreg(ADDR_FAULT_SETUP, 8'h06);
    wreg(7'h04, 8'h55);
    chk("status", o_fault_status, 8'h04);
    frame({1'b1, ADDR_FAULT_STATUS, 8'h00});
    rd(CREG_RDATA, s);
    chk("rdata", s[7:0], 8'h04);
    for (int k = 0; k < 3; k++) begin
      d = 8'($urandom);
      wreg(ADDR_SWITCH, d);
      chk("switch", o_switch_state, d);
      chk("status", o_fault_status, 8'h04);
    end
    frame(CLEAR_CMD);
    chk("status", o_fault_status, 8'h00);
    // Read of a write-only address
    frame({1'b1, ADDR_SOFT_RESET, 8'h00});
    chk("status", o_fault_status, 8'h04);
    frame(CLEAR_CMD);
    // 24 clocks into a 16-clock device
    wr(CREG_CTRL, 16'h0001);
    wreg(ADDR_SWITCH, ~d);
    chk("status", o_fault_status, 8'h02);
    chk("switch", o_switch_state, d);
    wr(CREG_CTRL, 16'h0000);
    frame(CLEAR_CMD);
    // CRC mode
    wreg(ADDR_FAULT_SETUP, 8'h07);
    chk("setup", o_fault_setup, 8'h07);
    wr(CREG_CTRL, 16'h0001);
    d = 8'($urandom);
    wreg(ADDR_SWITCH, d);
    chk("switch", o_switch_state, d);
    chk("status", o_fault_status, 8'h00);
    wr(CREG_CTRL, 16'h0000);
    wreg(ADDR_SWITCH, ~d);
    chk("cnt flag", {7'h00, o_fault_status[1]}, 8'h01);
    chk("switch", o_switch_state, d);
    // Corrupted CRC byte on a write and on the clear
    wr(CREG_CTRL, 16'h0003);
    rd(CREG_CTRL, s);
    chk("ctrl", s[7:0], 8'h03);
    wreg(ADDR_SWITCH, ~d);
    chk("status", o_fault_status, 8'h03);
    chk("switch", o_switch_state, d);
    frame(CLEAR_CMD);
    chk("status", o_fault_status, 8'h03);
    wr(CREG_CTRL, 16'h0001);
    frame(CLEAR_CMD);
    chk("status", o_fault_status, 8'h00);
    // Burst mode, with and without CRC
    wreg(ADDR_BURST, 8'h01);
    chk("burst", {7'h00, o_burst_mode}, 8'h01);
    wreg(ADDR_SWITCH, ~d);
    chk("switch", o_switch_state, ~d);
    wreg(ADDR_FAULT_SETUP, 8'h06);
    wr(CREG_CTRL, 16'h0000);
    wreg(ADDR_SWITCH, d);
    chk("switch", o_switch_state, d);
    chk("status", o_fault_status, 8'h00);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
